/* shared/pfs_pkg.sv */
package pfs_pkg;
    localparam int PFS_PORTP_W = 6;
    localparam int PFS_PORTS_W = 8;
    localparam int PFS_PORTT_W = 8;
    localparam int PFS_PORTAD_W = 16;
    localparam int PFS_ADDR_W = 16;
    localparam int PFS_BYTE_W = 8;
    localparam logic [5:0] PFS_PORTP_PULL_EN_RST = 6'h00;
    localparam logic [7:0] PFS_PORTS_PULL_EN_RST = 8'hFF;
    localparam logic [7:0] PFS_PORTS_PULL_POL_RST = 8'hFF;
    localparam logic [7:0] PFS_PORTT_PULL_EN_RST = 8'h00;
    localparam int PFS_MODE_HIGH_BIT = 2;
    localparam int PFS_MODE_MID_BIT = 1;
    localparam int PFS_MODE_LOW_BIT = 0;
    localparam int PFS_RESET_STRETCH_CYCLES = 16;

    typedef enum logic [1:0] {
        PFS_FN_GPIO,
        PFS_FN_WAKEUP,
        PFS_FN_PWM,
        PFS_FN_SPI
    } pfs_port_p_fn_t;

    typedef struct packed {
        logic [2:0] mode;
        logic oscillator_select_strap;
        logic onchip_flash_enable;
    } pfs_straps_t;

    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } pfs_pin_t;
endpackage

/* src/pfs_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_cell (
    input wire logic sel_alt_in,
    input wire logic gpio_out_in,
    input wire logic gpio_oe_in,
    input wire logic alt_out_in,
    input wire logic alt_oe_in,
    input wire logic pull_en_in,
    input wire logic pull_up_in,
    output logic pin_out,
    output logic pin_oe_out,
    output logic pull_up_out,
    output logic pull_down_out
);
    wire logic drive = sel_alt_in ? alt_oe_in : gpio_oe_in;
    assign pin_out = sel_alt_in ? alt_out_in : gpio_out_in;
    assign pin_oe_out = drive;
    // Pull stays off while the pin is driven
    assign pull_up_out = pull_en_in & pull_up_in & ~drive;
    assign pull_down_out = pull_en_in & ~pull_up_in & ~drive;
endmodule
`default_nettype wire

/* src/pfs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta <= '0;
            q_out <= '0;
        end else if (ce_in) begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

/* src/pfs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_top #(
    parameter int STRETCH = pfs_pkg::PFS_RESET_STRETCH_CYCLES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic crystal_input_in,
    output logic core_clk_out,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    input wire logic internal_reset_in,
    output logic core_resetn_out,
    output pfs_pkg::pfs_straps_t straps_out,
    input wire logic expanded_in,
    input wire logic tagging_en_in,
    input wire logic free_cycle_en_in,
    input wire logic bus_idle_in,
    input wire logic bus_clk_in,
    output logic tag_upper_half_out,
    input wire logic background_debug_pin_in,
    output logic background_debug_pin_out,
    output logic background_debug_pin_oe_out,
    input wire logic bdm_drive_low_in,
    input wire logic bdm_speedup_in,
    output logic bdm_rx_out,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pin_in,
    output logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pin_out,
    output logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pin_oe_out,
    input wire logic [2*pfs_pkg::PFS_PORTP_W-1:0] port_p_fn_in,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_gpio_out_in,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_gpio_oe_in,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pwm_in,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_spi_out_in,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_spi_oe_in,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pull_enable_in,
    input wire logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pull_polarity_in,
    output logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_wakeup_interrupt_out,
    output logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_data_out,
    output logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pull_up_out,
    output logic [pfs_pkg::PFS_PORTP_W-1:0] port_p_pull_down_out,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_pin_in,
    output logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_pin_out,
    output logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_pin_oe_out,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_alt_sel_in,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_gpio_out_in,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_gpio_oe_in,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_periph_out_in,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_periph_oe_in,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_pull_enable_in,
    input wire logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_pull_polarity_in,
    input wire logic port_s_pull_load_in,
    output logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_data_out,
    output logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_pull_up_out,
    output logic [pfs_pkg::PFS_PORTS_W-1:0] port_s_pull_down_out,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_pin_in,
    output logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_pin_out,
    output logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_pin_oe_out,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_timer_sel_in,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_gpio_out_in,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_gpio_oe_in,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] timer_channel_io_out_in,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] timer_channel_io_oe_in,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_pull_enable_in,
    input wire logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_pull_polarity_in,
    output logic [pfs_pkg::PFS_PORTT_W-1:0] timer_channel_io_out,
    output logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_pull_up_out,
    output logic [pfs_pkg::PFS_PORTT_W-1:0] port_t_pull_down_out,
    input wire logic [pfs_pkg::PFS_PORTAD_W-1:0] port_ad_pin_in,
    output logic [pfs_pkg::PFS_PORTAD_W-1:0] port_ad_data_out,
    output logic [pfs_pkg::PFS_PORTAD_W-1:0] analog_channel_out,
    input wire logic [pfs_pkg::PFS_BYTE_W-1:0] port_a_pin_in,
    input wire logic [pfs_pkg::PFS_BYTE_W-1:0] port_b_pin_in,
    output logic [pfs_pkg::PFS_BYTE_W-1:0] port_a_pin_out,
    output logic [pfs_pkg::PFS_BYTE_W-1:0] port_b_pin_out,
    output logic port_ab_oe_out,
    input wire logic [pfs_pkg::PFS_ADDR_W-1:0] bus_ad_out_in,
    input wire logic bus_ad_oe_in,
    input wire logic [pfs_pkg::PFS_ADDR_W-1:0] port_ab_gpio_out_in,
    input wire logic port_ab_gpio_oe_in,
    output logic [pfs_pkg::PFS_ADDR_W-1:0] port_ab_data_out,
    input wire logic port_e7_pin_in,
    input wire logic port_e6_pin_in,
    input wire logic port_e5_pin_in,
    input wire logic port_k7_pin_in,
    input wire logic port_e7_gpio_out_in,
    input wire logic port_e7_gpio_oe_in,
    output logic port_e7_pin_out,
    output logic port_e7_pin_oe_out,
    output logic port_e7_pull_up_out,
    input wire logic [1:0] pipe_status_in,
    input wire logic [1:0] port_e65_gpio_out_in,
    input wire logic [1:0] port_e65_gpio_oe_in,
    output logic [1:0] port_e65_pin_out,
    output logic [1:0] port_e65_pin_oe_out,
    input wire logic emulation_chip_select_in,
    input wire logic port_k7_gpio_out_in,
    input wire logic port_k7_gpio_oe_in,
    output logic port_k7_pin_out,
    output logic port_k7_pin_oe_out
);
    import pfs_pkg::*;

    if (STRETCH < 1 || STRETCH > 255) begin : g_bad_stretch
        $error("STRETCH out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int SYN_W = PFS_PORTP_W + PFS_PORTS_W + PFS_PORTT_W + PFS_PORTAD_W
        + 2 * PFS_BYTE_W + 7;
    logic [SYN_W-1:0] syn_q;
    pfs_sync #(.WIDTH(SYN_W)) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .d_in({port_p_pin_in, port_s_pin_in, port_t_pin_in, port_ad_pin_in,
            port_a_pin_in, port_b_pin_in, reset_pin_in, background_debug_pin_in,
            bus_clk_in, port_e7_pin_in, port_e6_pin_in, port_e5_pin_in,
            port_k7_pin_in}),
        .q_out(syn_q)
    );
    wire logic [PFS_PORTP_W-1:0] p_s;
    wire logic [PFS_PORTS_W-1:0] s_s;
    wire logic [PFS_PORTT_W-1:0] t_s;
    wire logic [PFS_PORTAD_W-1:0] ad_s;
    wire logic [PFS_BYTE_W-1:0] a_s;
    wire logic [PFS_BYTE_W-1:0] b_s;
    wire logic rst_s, background_debug_pin_s, eclk_s, e7_s, e6_s, e5_s, k7_s;
    assign {p_s, s_s, t_s, ad_s, a_s, b_s, rst_s, background_debug_pin_s, eclk_s, e7_s, e6_s, e5_s,
        k7_s} = syn_q;

    ////////////////////////////////////////////////////////////////////////
    // Reset pin and strap capture
    logic [7:0] stretch;
    logic in_reset;
    logic in_reset_d;
    pfs_straps_t straps;
    wire logic release_pulse = in_reset_d & ~in_reset;
    wire logic int_fire = internal_reset_in;
    // Stretch internal resets so the board sees a clear low
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stretch <= 8'h00;
        end else if (ce_in) begin
            if (int_fire) begin
                stretch <= 8'(STRETCH);
            end else if (stretch != 8'h00) begin
                stretch <= stretch - 8'h01;
            end
        end
    end
    wire logic drive_reset = int_fire | (stretch != 8'h00);
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_out = drive_reset;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            in_reset <= 1'b1;
            in_reset_d <= 1'b1;
        end else if (ce_in) begin
            in_reset <= ~rst_s | drive_reset;
            in_reset_d <= in_reset;
        end
    end
    assign core_resetn_out = ~in_reset;
    // E7 strap defaults to the pulled-up state when the pin floats; E6, E5 and K7 get no pull
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            straps <= '0;
        end else if (ce_in && release_pulse) begin
            straps.mode[PFS_MODE_HIGH_BIT] <= background_debug_pin_s;
            straps.mode[PFS_MODE_MID_BIT] <= e6_s;
            straps.mode[PFS_MODE_LOW_BIT] <= e5_s;
            straps.oscillator_select_strap <= e7_s;
            straps.onchip_flash_enable <= k7_s;
        end
    end
    assign straps_out = straps;
    // Clock chosen from crystal input only
    assign core_clk_out = crystal_input_in;

    ////////////////////////////////////////////////////////////////////////
    // Debug pin and tagging
    logic eclk_d;
    logic tag;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            eclk_d <= 1'b0;
            tag <= 1'b0;
        end else if (ce_in) begin
            eclk_d <= eclk_s;
            tag <= expanded_in & tagging_en_in & eclk_d & ~eclk_s & ~background_debug_pin_s;
        end
    end
    assign tag_upper_half_out = tag;
    // Brief high drive speeds the rising edge; never drives high while low pulls
    assign background_debug_pin_out = bdm_speedup_in & ~bdm_drive_low_in;
    assign background_debug_pin_oe_out = ~in_reset & (bdm_drive_low_in | bdm_speedup_in);
    assign bdm_rx_out = background_debug_pin_s;

    ////////////////////////////////////////////////////////////////////////
    // Port P
    logic [PFS_PORTP_W-1:0] p_alt_sel, p_alt_out, p_alt_oe, p_wake;
    pfs_port_p_fn_t p_fn [PFS_PORTP_W];
    genvar gi;
    generate
        for (gi = 0; gi < PFS_PORTP_W; gi++) begin : g_p
            assign p_fn[gi] = pfs_port_p_fn_t'(port_p_fn_in[2*gi +: 2]);
            always_comb begin
                case (p_fn[gi])
                    PFS_FN_PWM: begin
                        p_alt_sel[gi] = 1'b1;
                        p_alt_out[gi] = port_p_pwm_in[gi];
                        p_alt_oe[gi] = 1'b1;
                        p_wake[gi] = 1'b0;
                    end
                    PFS_FN_SPI: begin
                        p_alt_sel[gi] = 1'b1;
                        p_alt_out[gi] = port_p_spi_out_in[gi];
                        p_alt_oe[gi] = port_p_spi_oe_in[gi];
                        p_wake[gi] = 1'b0;
                    end
                    PFS_FN_WAKEUP: begin
                        p_alt_sel[gi] = 1'b1;
                        p_alt_out[gi] = 1'b0;
                        p_alt_oe[gi] = 1'b0;
                        p_wake[gi] = 1'b1;
                    end
                    default: begin
                        p_alt_sel[gi] = 1'b0;
                        p_alt_out[gi] = 1'b0;
                        p_alt_oe[gi] = 1'b0;
                        p_wake[gi] = 1'b0;
                    end
                endcase
            end
            pfs_pin_cell u_p (
                .sel_alt_in(p_alt_sel[gi]),
                .gpio_out_in(port_p_gpio_out_in[gi]),
                .gpio_oe_in(port_p_gpio_oe_in[gi] & ~in_reset),
                .alt_out_in(p_alt_out[gi]),
                .alt_oe_in(p_alt_oe[gi] & ~in_reset),
                .pull_en_in(port_p_pull_enable_in[gi] & ~in_reset),
                .pull_up_in(~port_p_pull_polarity_in[gi]),
                .pin_out(port_p_pin_out[gi]),
                .pin_oe_out(port_p_pin_oe_out[gi]),
                .pull_up_out(port_p_pull_up_out[gi]),
                .pull_down_out(port_p_pull_down_out[gi])
            );
            assign port_p_wakeup_interrupt_out[gi] = p_wake[gi] & ~p_s[gi];
        end
    endgenerate
    assign port_p_data_out = p_s;

    ////////////////////////////////////////////////////////////////////////
    // Port S; pull settings held in flops so reset shows pull-ups
    logic [PFS_PORTS_W-1:0] s_pull_en, s_pull_pol;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_pull_en <= PFS_PORTS_PULL_EN_RST;
            s_pull_pol <= PFS_PORTS_PULL_POL_RST;
        end else if (ce_in) begin
            if (in_reset) begin
                s_pull_en <= PFS_PORTS_PULL_EN_RST;
                s_pull_pol <= PFS_PORTS_PULL_POL_RST;
            end else if (port_s_pull_load_in) begin
                s_pull_en <= port_s_pull_enable_in;
                s_pull_pol <= port_s_pull_polarity_in;
            end
        end
    end
    generate
        for (gi = 0; gi < PFS_PORTS_W; gi++) begin : g_s
            pfs_pin_cell u_s (
                .sel_alt_in(port_s_alt_sel_in[gi]),
                .gpio_out_in(port_s_gpio_out_in[gi]),
                .gpio_oe_in(port_s_gpio_oe_in[gi] & ~in_reset),
                .alt_out_in(port_s_periph_out_in[gi]),
                .alt_oe_in(port_s_periph_oe_in[gi] & ~in_reset),
                .pull_en_in(s_pull_en[gi]),
                .pull_up_in(s_pull_pol[gi]),
                .pin_out(port_s_pin_out[gi]),
                .pin_oe_out(port_s_pin_oe_out[gi]),
                .pull_up_out(port_s_pull_up_out[gi]),
                .pull_down_out(port_s_pull_down_out[gi])
            );
        end
        for (gi = 0; gi < PFS_PORTT_W; gi++) begin : g_t
            pfs_pin_cell u_t (
                .sel_alt_in(port_t_timer_sel_in[gi]),
                .gpio_out_in(port_t_gpio_out_in[gi]),
                .gpio_oe_in(port_t_gpio_oe_in[gi] & ~in_reset),
                .alt_out_in(timer_channel_io_out_in[gi]),
                .alt_oe_in(timer_channel_io_oe_in[gi] & ~in_reset),
                .pull_en_in(port_t_pull_enable_in[gi] & ~in_reset),
                .pull_up_in(~port_t_pull_polarity_in[gi]),
                .pin_out(port_t_pin_out[gi]),
                .pin_oe_out(port_t_pin_oe_out[gi]),
                .pull_up_out(port_t_pull_up_out[gi]),
                .pull_down_out(port_t_pull_down_out[gi])
            );
        end
    endgenerate
    assign port_s_data_out = s_s;
    assign timer_channel_io_out = t_s;

    ////////////////////////////////////////////////////////////////////////
    // Port AD: analog path bypasses the synchroniser
    assign port_ad_data_out = ad_s;
    assign analog_channel_out = port_ad_pin_in;

    ////////////////////////////////////////////////////////////////////////
    // Expanded bus pins
    wire logic exp = expanded_in & ~in_reset;
    wire logic [PFS_ADDR_W-1:0] ab_sel = exp ? bus_ad_out_in : port_ab_gpio_out_in;
    assign port_a_pin_out = ab_sel[PFS_ADDR_W-1:PFS_BYTE_W];
    assign port_b_pin_out = ab_sel[PFS_BYTE_W-1:0];
    assign port_ab_oe_out = ~in_reset & (exp ? bus_ad_oe_in : port_ab_gpio_oe_in);
    assign port_ab_data_out = {a_s, b_s};
    wire logic free_mode = exp & free_cycle_en_in;
    assign port_e7_pin_out = free_mode ? bus_idle_in : port_e7_gpio_out_in;
    assign port_e7_pin_oe_out = free_mode | (~in_reset & port_e7_gpio_oe_in);
    assign port_e7_pull_up_out = in_reset;
    assign port_e65_pin_out = exp ? pipe_status_in : port_e65_gpio_out_in;
    assign port_e65_pin_oe_out = in_reset ? 2'h0 : (exp ? 2'h3 : port_e65_gpio_oe_in);
    assign port_k7_pin_out = exp ? emulation_chip_select_in : port_k7_gpio_out_in;
    assign port_k7_pin_oe_out = ~in_reset & (exp | port_k7_gpio_oe_in);

    ////////////////////////////////////////////////////////////////////////
    strap_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && !release_pulse |=> $stable(straps)) else $error("strap changed");
    strap_mode_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && release_pulse |=> straps.mode == {$past(background_debug_pin_s), $past(e6_s), $past(e5_s)})
        else $error("mode strap wrong");
    osc_strap_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && release_pulse |=> straps.oscillator_select_strap == $past(e7_s))
        else $error("osc strap wrong");
    reset_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        int_fire || ($past(ce_in) && $fell(int_fire)) |-> reset_pin_oe_out && !reset_pin_out)
        else $error("reset not driven");
    reset_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && int_fire |=> ##1 in_reset) else $error("no internal reset");
    tag_cause_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        tag_upper_half_out && $past(ce_in) |-> $past(expanded_in && tagging_en_in && !background_debug_pin_s))
        else $error("spurious tag");
    bdm_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        background_debug_pin_oe_out && bdm_drive_low_in |-> !background_debug_pin_out)
        else $error("debug pin driven high");
    free_cycle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        free_mode |-> port_e7_pin_oe_out && port_e7_pin_out == bus_idle_in)
        else $error("free cycle wrong");
    bus_mux_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exp |-> {port_a_pin_out, port_b_pin_out} == bus_ad_out_in)
        else $error("bus mux wrong");
    osc_pull_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        in_reset |-> port_e7_pull_up_out) else $error("osc pull missing");
endmodule
`default_nettype wire

/* sim/pfs_board.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_board (
    input wire logic rst_low_in,
    input wire logic dev_rst_oe_in,
    input wire logic host_low_in,
    input wire logic dbg_out_in,
    input wire logic dbg_oe_in,
    input wire logic e7_drive_in,
    input wire logic e7_value_in,
    input wire logic e7_pull_up_in,
    output logic reset_pin_out,
    output logic debug_pin_out,
    output logic e7_pin_out
);
    // Both sides may only pull the reset line low
    assign reset_pin_out = ~(rst_low_in | dev_rst_oe_in);
    // Released debug line rests high on its pull-up
    assign debug_pin_out = ~(host_low_in | (dbg_oe_in & ~dbg_out_in));
    // Floating strap without a pull-up reads back inverted, so a lost pull shows
    assign e7_pin_out = e7_drive_in ? e7_value_in : (e7_pull_up_in | ~e7_value_in);
endmodule
`default_nettype wire

/* sim/pin_function_and_reset_straps_test.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_function_and_reset_straps_test;
    import pfs_pkg::*;
    logic clk_in = 0, resetn_in = 0, ce_in = 1, crystal_input_in = 0, internal_reset_in = 0;
    logic expanded_in = 0, tagging_en_in = 0, free_cycle_en_in = 0, bus_idle_in = 0;
    logic bus_clk_in = 1, bdm_drive_low_in = 0, bdm_speedup_in = 0, port_s_pull_load_in = 0;
    logic bus_ad_oe_in = 0, port_ab_gpio_oe_in = 0, port_e6_pin_in = 0, port_e5_pin_in = 0;
    logic port_k7_pin_in = 0, port_e7_gpio_out_in = 0, port_e7_gpio_oe_in = 0;
    logic emulation_chip_select_in = 0, port_k7_gpio_out_in = 0, port_k7_gpio_oe_in = 0;
    logic rst_low = 0, dbg_low = 0, e7_drv = 1, e7_val = 0;
    wire logic reset_pin_in, background_debug_pin_in, port_e7_pin_in;
    logic core_clk_out, reset_pin_out, reset_pin_oe_out, core_resetn_out, tag_upper_half_out;
    logic background_debug_pin_out, background_debug_pin_oe_out, bdm_rx_out, port_ab_oe_out;
    logic port_e7_pin_out, port_e7_pin_oe_out, port_e7_pull_up_out, port_k7_pin_out;
    logic port_k7_pin_oe_out;
    pfs_straps_t straps_out;
    logic [11:0] port_p_fn_in = '0;
    logic [5:0] port_p_pin_in = '0, port_p_gpio_out_in = '0, port_p_gpio_oe_in = '0;
    logic [5:0] port_p_pwm_in = '0, port_p_spi_out_in = '0, port_p_spi_oe_in = '0;
    logic [5:0] port_p_pull_enable_in = '0, port_p_pull_polarity_in = '0, port_p_pin_out;
    logic [5:0] port_p_pin_oe_out, port_p_wakeup_interrupt_out, port_p_data_out;
    logic [5:0] port_p_pull_up_out, port_p_pull_down_out;
    logic [7:0] port_s_pin_in = '0, port_s_alt_sel_in = '0, port_s_gpio_out_in = '0;
    logic [7:0] port_s_gpio_oe_in = '0, port_s_periph_out_in = '0, port_s_periph_oe_in = '0;
    logic [7:0] port_s_pull_enable_in = '0, port_s_pull_polarity_in = '0, port_s_pin_out;
    logic [7:0] port_s_pin_oe_out, port_s_data_out, port_s_pull_up_out, port_s_pull_down_out;
    logic [7:0] port_t_pin_in = '0, port_t_timer_sel_in = '0, port_t_gpio_out_in = '0;
    logic [7:0] port_t_gpio_oe_in = '0, timer_channel_io_out_in = '0, timer_channel_io_oe_in = '0;
    logic [7:0] port_t_pull_enable_in = '0, port_t_pull_polarity_in = '0, port_t_pin_out;
    logic [7:0] port_t_pin_oe_out, timer_channel_io_out, port_t_pull_up_out, port_t_pull_down_out;
    logic [7:0] port_a_pin_in = '0, port_b_pin_in = '0, port_a_pin_out, port_b_pin_out;
    logic [15:0] port_ad_pin_in = '0, port_ad_data_out, analog_channel_out, port_ab_data_out;
    logic [15:0] bus_ad_out_in = '0, port_ab_gpio_out_in = '0;
    logic [1:0] pipe_status_in = '0, port_e65_gpio_out_in = '0, port_e65_gpio_oe_in = '0;
    logic [1:0] port_e65_pin_out, port_e65_pin_oe_out;
    int mismatches = 0, checks = 0, cycles = 0;
    // Short stretch keeps the reset scenarios brief
    pfs_top #(.STRETCH(2)) dut (.*);
    pfs_board board (.rst_low_in(rst_low), .dev_rst_oe_in(reset_pin_oe_out), .host_low_in(dbg_low),
        .dbg_out_in(background_debug_pin_out), .dbg_oe_in(background_debug_pin_oe_out),
        .e7_drive_in(e7_drv), .e7_value_in(e7_val), .e7_pull_up_in(port_e7_pull_up_out),
        .reset_pin_out(reset_pin_in), .debug_pin_out(background_debug_pin_in),
        .e7_pin_out(port_e7_pin_in));
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic e(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wait_up();
        int n = 0;
        while (core_resetn_out !== 1'b1 && n < 60) begin
            e(1);
            n++;
        end
        chk(n < 60, 1);
    endtask
    ////////////////////////////////////////////////////////////////
    // Strap order: debug, E6, E5, E7, K7
    task automatic straps_test(input logic [4:0] s, input logic fl);
        e(1);
        {dbg_low, port_e6_pin_in, port_e5_pin_in, e7_val, port_k7_pin_in} <= s ^ 5'h10;
        e7_drv <= ~fl;
        rst_low <= 1;
        e(4);
        rst_low <= 0;
        wait_up();
        #1 chk(straps_out, s);
        chk(port_s_pull_up_out, 8'hFF);
        e(1);
        port_e6_pin_in <= ~s[3];
        dbg_low <= s[4];
        e7_drv <= 1;
        e7_val <= ~s[1];
        e(4);
        #1 chk(straps_out, s);
    endtask
    task automatic stretch_test();
        e(1);
        internal_reset_in <= 1;
        #1 chk(reset_pin_oe_out, 1);
        e(3);
        internal_reset_in <= 0;
        e(1);
        #1 chk(reset_pin_oe_out, 1);
        e(3);
        #1 chk(reset_pin_oe_out, 0);
        wait_up();
    endtask
    task automatic port_p_test();
        e(1);
        port_p_gpio_out_in <= 6'h15;
        port_p_pwm_in <= 6'h2A;
        port_p_spi_out_in <= 6'h33;
        port_p_gpio_oe_in <= 6'h3F;
        port_p_spi_oe_in <= 6'h3F;
        port_ad_pin_in <= 16'h5AA5;
        for (int f = 0; f < 4; f++) begin
            e(1);
            port_p_fn_in <= {6{2'(f)}};
            e(3);
            #1 chk(f == 1 ? port_p_wakeup_interrupt_out : port_p_pin_out,
                f == 0 ? 6'h15 : f == 1 ? 6'h3F : f == 2 ? 6'h2A : 6'h33);
        end
        e(1);
        port_p_fn_in <= '0;
        port_p_gpio_oe_in <= '0;
        port_p_pull_enable_in <= 6'h3F;
        port_p_pull_polarity_in <= 6'h0F;
        port_s_pull_enable_in <= 8'h0F;
        port_s_pull_polarity_in <= 8'h03;
        port_s_pull_load_in <= 1;
        port_t_pull_enable_in <= 8'h0F;
        port_t_pull_polarity_in <= 8'h03;
        #1 chk({port_p_pull_up_out, port_p_pull_down_out}, 12'hC0F);
        chk(analog_channel_out, 16'h5AA5);
        chk(port_ad_data_out, 16'h5AA5);
        e(1);
        port_s_pull_load_in <= 0;
        #1 chk({port_s_pull_up_out, port_s_pull_down_out}, 16'h030C);
        chk({port_t_pull_up_out, port_t_pull_down_out}, 16'h0C03);
    endtask
    task automatic bus_test();
        e(1);
        expanded_in <= 1;
        bus_ad_out_in <= 16'h1234;
        bus_ad_oe_in <= 1;
        port_ab_gpio_out_in <= 16'hABCD;
        port_ab_gpio_oe_in <= 1;
        free_cycle_en_in <= 1;
        bus_idle_in <= 1;
        crystal_input_in <= 1;
        pipe_status_in <= 2'h2;
        emulation_chip_select_in <= 1;
        #1 chk({port_a_pin_out, port_b_pin_out}, 16'h1234);
        chk({port_e65_pin_out, port_e65_pin_oe_out, port_k7_pin_out, port_k7_pin_oe_out}, 6'h2F);
        chk({port_e7_pin_oe_out, port_e7_pin_out, core_clk_out}, 3'h7);
        e(1);
        expanded_in <= 0;
        #1 chk({port_a_pin_out, port_b_pin_out, port_ab_oe_out}, 17'h1579B);
    endtask
    task automatic tag_test();
        int n;
        e(1);
        expanded_in <= 1;
        tagging_en_in <= 1;
        // Second pass keeps the debug pin high, so no tag may appear
        for (int k = 0; k < 2; k++) begin
            n = 0;
            e(1);
            dbg_low <= ~k[0];
            bus_clk_in <= 1;
            e(4);
            bus_clk_in <= 0;
            repeat (10) begin
                e(1);
                #1 n += tag_upper_half_out;
            end
            chk(n, k == 0);
        end
        e(1);
        bdm_drive_low_in <= 1;
        #1 chk({background_debug_pin_oe_out, background_debug_pin_out}, 2'h2);
    endtask
    initial begin
        e(3);
        resetn_in <= 1;
        wait_up();
        straps_test(5'h15, 0);
        straps_test(5'h0A, 1);
        stretch_test();
        port_p_test();
        bus_test();
        tag_test();
        give_verdict();
    end
endmodule
`default_nettype wire
